/* File: hw/enc_node_ind.sv */
// enc_node_ind: switch decode, indicator drive and terminator control
// assumes rotary switches on async pins and can status from same-clock logic
//
// What this block does
// [RULE1] node address from tens and units switches
// [RULE2] addresses 0 to 89 are valid
// [RULE3] addresses 90 to 99 are reserved
// [RULE4] node number is switch address plus one
// [RULE5] rate codes 0-7 map rates, 8 reserved
// [RULE6] rate code 9 takes config from software
// [RULE7] detection or lss flickers both indicators
// [RULE8] run blinks in pre-operational
// [RULE9] run single flash in stopped
// [RULE10] run triple flash during download
// [RULE11] run steady on in operational
// [RULE12] error dark with no error
// [RULE13] error single flash at warning level
// [RULE14] error double flash on guard/heartbeat event
// [RULE15] error triple flash on sync timeout
// [RULE16] error quadruple flash on pdo timeout
// [RULE17] error steady on while bus off
// [RULE18] writing 01 enables the terminator
// [RULE19] terminator only active while powered
// [RULE20] flicker 10 hz, blink 2.5 hz, flashes
// [RULE21] error blinks on configuration error
`timescale 1ns/1ps
`default_nettype none
module enc_node_ind
	import enc_pkg::*;
#(
	parameter int TICK_CYC_P = TICK_CYC
) (
	input  wire logic         mclk,        // node clock
	input  wire logic         rst,         // sync reset
	input  wire enc_axi_req_t axi_req,     // register bus in
	output enc_axi_rsp_t      axi_rsp,     // register bus out
	input  wire logic [3:0]   tens_digit_switch,        // async pin
	input  wire logic [3:0]   units_digit_switch,       // async pin
	input  wire logic [3:0]   bit_rate_selector_switch, // async pin
	input  wire logic         can_warn,    // error counter at warning
	input  wire logic         can_bus_off, // controller bus off
	input  wire logic         guard_evt,   // guard/heartbeat pulse
	input  wire logic         sync_to_evt, // sync timeout pulse
	input  wire logic         pdo_to_evt,  // pdo timer pulse
	output logic [6:0]        node_id,     // effective node number
	output logic [2:0]        rate_code,   // selected bit rate
	output logic              soft_cfg,    // software config mode
	output logic              term_on,     // terminator switch
	output logic              run_led,     // green indicator
	output logic              err_led      // red indicator
);
	logic [11:0] sw_m, sw_s;
	logic [7:0]  ctrl, term;
	logic [11:0] scfg;
	logic [2:0]  err_flag;
	logic [31:0] wdat;
	logic [7:0]  waddr;
	logic [3:0]  wstb;
	logic [22:0] tick_cnt;
	logic [1:0]  sub;
	logic        flick;
	logic        cfg_err;
	logic [3:0]  step [2];
	enc_pat_t    pat_q [2];
	logic [1:0]  led_q;

	// two-stage synchroniser for the switch pins
	always_ff @(posedge mclk) begin
		sw_m <= {tens_digit_switch, units_digit_switch, bit_rate_selector_switch};
		sw_s <= sw_m;
	end

	// switch decode
	wire [3:0] s_tens  = sw_s[11:8];
	wire [3:0] s_units = sw_s[7:4];
	wire [3:0] s_rate  = sw_s[3:0];
	wire [6:0] sw_addr = {s_tens, 3'b000} + {2'b00, s_tens, 1'b0} + {3'b000, s_units}; // RULE1
	wire addr_ok = (s_tens <= TENS_MAX) && (s_units <= UNITS_MAX); // RULE2 RULE3
	wire is_soft = (s_rate == RATE_SOFT); // RULE6
	wire rate_ok = (s_rate < RATE_RSV); // RULE5
	wire [3:0] sr = scfg[SCFG_RATE +: 4];
	wire soft_ok = (sr < RATE_RSV) && (scfg[6:0] != 7'h7F);
	wire src_ok = is_soft ? soft_ok : (addr_ok && rate_ok);
	wire [6:0] next_node = is_soft ? scfg[6:0] + NODE_ADD : sw_addr + NODE_ADD; // RULE4
	wire [2:0] next_rate = is_soft ? sr[2:0] : s_rate[2:0]; // RULE5

	// take a new node and rate only from a valid source
	always_ff @(posedge mclk) begin
		if (rst) begin
			node_id   <= NODE_RST;
			rate_code <= SCFG_RATE_RST[2:0];
			soft_cfg  <= 1'b0;
			cfg_err   <= 1'b0;
		end else begin
			soft_cfg <= is_soft;
			cfg_err  <= !src_ok; // RULE21
			if (src_ok) begin
				node_id   <= next_node;
				rate_code <= next_rate;
			end
		end
	end

	// bus write decode
	wire wr_do   = !axi_rsp.awready && !axi_rsp.wready && !axi_rsp.bvalid;
	wire w_ctrl  = wr_do && waddr == OFF_CTRL && wstb[0];
	wire w_term  = wr_do && waddr == OFF_TERM && wstb[0];
	wire w_err   = wr_do && waddr == OFF_ERR && wstb[0];
	wire w_scfg0 = wr_do && waddr == OFF_SCFG && wstb[0];
	wire w_scfg1 = wr_do && waddr == OFF_SCFG && wstb[1];
	wire w_map   = waddr == OFF_CTRL || waddr == OFF_TERM || waddr == OFF_SCFG
		|| waddr == OFF_ERR || waddr == OFF_STAT;
	wire ar_fire = axi_req.arvalid && axi_rsp.arready;

	// write address and data capture, in either order
	always_ff @(posedge mclk) begin
		if (rst) begin
			axi_rsp.awready <= 1'b1;
			axi_rsp.wready  <= 1'b1;
			axi_rsp.bvalid  <= 1'b0;
			axi_rsp.bresp   <= RESP_OK;
			waddr <= 8'h00;
			wdat  <= 32'h0000_0000;
			wstb  <= 4'h0;
		end else begin
			if (axi_req.awvalid && axi_rsp.awready) begin
				axi_rsp.awready <= 1'b0;
				waddr <= {axi_req.awaddr[7:2], 2'b00};
			end
			if (axi_req.wvalid && axi_rsp.wready) begin
				axi_rsp.wready <= 1'b0;
				wdat <= axi_req.wdata;
				wstb <= axi_req.wstrb;
			end
			if (wr_do) begin
				axi_rsp.bvalid <= 1'b1;
				axi_rsp.bresp  <= w_map ? RESP_OK : RESP_ERR;
			end
			if (axi_rsp.bvalid && axi_req.bready) begin
				axi_rsp.bvalid  <= 1'b0;
				axi_rsp.awready <= 1'b1;
				axi_rsp.wready  <= 1'b1;
			end
		end
	end

	// control register: nmt state and activity flags
	always_ff @(posedge mclk) begin
		if (rst) ctrl <= 8'h00;
		else if (w_ctrl) ctrl <= {3'b000, wdat[4:0]};
	end

	// terminator object, cleared at power-up
	always_ff @(posedge mclk) begin
		if (rst) begin
			term    <= TERM_RST; // RULE19
			term_on <= 1'b0;
		end else begin
			if (w_term) term <= wdat[7:0];
			term_on <= (term == TERM_ON_VAL); // RULE18
		end
	end

	// software node and rate object
	always_ff @(posedge mclk) begin
		if (rst) scfg <= {SCFG_RATE_RST, 1'b0, SCFG_NODE_RST};
		else begin
			if (w_scfg0) scfg[6:0] <= wdat[6:0];
			if (w_scfg1) scfg[11:8] <= wdat[11:8];
		end
	end

	// sticky error events, a new event wins over the clear
	wire [2:0] err_set = {pdo_to_evt, sync_to_evt, guard_evt};
	wire [2:0] err_clr = w_err ? wdat[2:0] : 3'b000;
	always_ff @(posedge mclk) begin
		if (rst) err_flag <= 3'b000;
		else err_flag <= (err_flag & ~err_clr) | err_set; // RULE14 RULE15 RULE16
	end

	// read data select
	logic [31:0] rd_mux;
	assign rd_mux =
		(axi_req.araddr[7:2] == OFF_CTRL[7:2]) ? {24'h0, ctrl} :
		(axi_req.araddr[7:2] == OFF_TERM[7:2]) ? {24'h0, term} :
		(axi_req.araddr[7:2] == OFF_SCFG[7:2]) ? {20'h0, scfg} :
		(axi_req.araddr[7:2] == OFF_ERR[7:2])  ?
			{22'h0, can_bus_off, can_warn, 5'h00, err_flag} :
		(axi_req.araddr[7:2] == OFF_STAT[7:2]) ?
			{13'h0, term_on, err_led, run_led, 2'b00, cfg_err, soft_cfg,
			1'b0, rate_code, 1'b0, node_id} :
		32'h0000_0000;
	wire r_map = axi_req.araddr[7:2] <= OFF_STAT[7:2];

	// read channel, one outstanding
	always_ff @(posedge mclk) begin
		if (rst) begin
			axi_rsp.arready <= 1'b1;
			axi_rsp.rvalid  <= 1'b0;
			axi_rsp.rdata   <= 32'h0000_0000;
			axi_rsp.rresp   <= RESP_OK;
		end else if (ar_fire) begin
			axi_rsp.arready <= 1'b0;
			axi_rsp.rvalid  <= 1'b1;
			axi_rsp.rdata   <= rd_mux;
			axi_rsp.rresp   <= r_map ? RESP_OK : RESP_ERR;
		end else if (axi_rsp.rvalid && axi_req.rready) begin
			axi_rsp.rvalid  <= 1'b0;
			axi_rsp.arready <= 1'b1;
		end
	end

	// 50 ms tick, 200 ms slot, flicker phase
	wire tick = (tick_cnt == 23'(TICK_CYC_P - 1));
	wire slot = tick && (sub == SLOT_TICKS);
	always_ff @(posedge mclk) begin
		if (rst) begin
			tick_cnt <= 23'h0;
			sub      <= 2'h0;
			flick    <= 1'b0;
		end else begin
			tick_cnt <= tick ? 23'h0 : tick_cnt + 23'h1;
			if (tick) begin
				sub   <= sub + 2'h1;
				flick <= !flick; // RULE20
			end
		end
	end

	// pattern choice for each indicator
	wire busy = ctrl[CTRL_ABR] || ctrl[CTRL_LSS];
	enc_pat_t pat_run, pat_err;
	wire enc_nmt_t nmt = enc_nmt_t'(ctrl[1:0]);
	assign pat_run = busy ? PAT_FLICK : // RULE7
		ctrl[CTRL_DL] ? PAT_F3 : // RULE10
		(nmt == NMT_OPER) ? PAT_ON : // RULE11
		(nmt == NMT_STOP) ? PAT_F1 : // RULE9
		(nmt == NMT_PREOP) ? PAT_BLINK : PAT_OFF; // RULE8
	assign pat_err = busy ? PAT_FLICK : // RULE7
		can_bus_off ? PAT_ON : // RULE17
		err_flag[2] ? PAT_F4 : // RULE16
		err_flag[1] ? PAT_F3 : // RULE15
		err_flag[0] ? PAT_F2 : // RULE14
		can_warn ? PAT_F1 : // RULE13
		cfg_err ? PAT_BLINK : PAT_OFF; // RULE21 RULE12

	// slots in one period of a pattern
	function automatic logic [3:0] pat_len(input enc_pat_t p);
		logic [3:0] n;
		n = {1'b0, 3'(p) - 3'(PAT_F1)} + 4'h1;
		pat_len = (p == PAT_BLINK) ? 4'h2 : {n[2:0], 1'b0} - 4'h1 + PAT_SLOTS();
	endfunction
	function automatic logic [3:0] PAT_SLOTS();
		PAT_SLOTS = PAUSE_SLOTS;
	endfunction

	// indicator level for pattern and slot
	function automatic logic pat_lit(input enc_pat_t p, input logic [3:0] s, input logic f);
		logic [3:0] n;
		n = {1'b0, 3'(p) - 3'(PAT_F1)} + 4'h1;
		unique case (p)
			PAT_OFF:   pat_lit = 1'b0;
			PAT_ON:    pat_lit = 1'b1;
			PAT_FLICK: pat_lit = f;
			PAT_BLINK: pat_lit = (s == 4'h0);
			default:   pat_lit = !s[0] && (s < {n[2:0], 1'b0}); // RULE20
		endcase
	endfunction

	// one sequencer per indicator, restarts on a pattern change
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_led
			wire enc_pat_t p = (gi == 0) ? pat_run : pat_err;
			wire [3:0] next_step = (step[gi] + 4'h1 == pat_len(p)) ? 4'h0 : step[gi] + 4'h1;
			always_ff @(posedge mclk) begin
				if (rst) begin
					step[gi]  <= 4'h0;
					pat_q[gi] <= PAT_OFF;
					led_q[gi] <= 1'b0;
				end else begin
					pat_q[gi] <= p;
					if (p != pat_q[gi]) step[gi] <= 4'h0;
					else if (slot) step[gi] <= next_step;
					led_q[gi] <= pat_lit(p, step[gi], flick);
				end
			end
		end
	endgenerate
	assign run_led = led_q[0];
	assign err_led = led_q[1];

	// checks
	sequence s_term_wr;
		w_term && wdat[7:0] == TERM_ON_VAL;
	endsequence
	a_term_enable: assert property (@(posedge mclk) disable iff (rst) // RULE18
		s_term_wr |-> ##1 !w_term[*1] ##1 term_on)
		else $error("terminator not switched on");
	a_node_plus_one: assert property (@(posedge mclk) disable iff (rst) // RULE4
		!is_soft && addr_ok && rate_ok |=> node_id == $past(sw_addr) + NODE_ADD)
		else $error("node number not address plus one");
	a_rsv_addr: assert property (@(posedge mclk) disable iff (rst) // RULE3
		!is_soft && s_tens > TENS_MAX |=> cfg_err && node_id == $past(node_id))
		else $error("reserved address accepted");
	a_soft_src: assert property (@(posedge mclk) disable iff (rst) // RULE6
		is_soft && soft_ok |=> soft_cfg && rate_code == $past(sr[2:0]))
		else $error("software config not used");
	a_flick_both: assert property (@(posedge mclk) disable iff (rst) // RULE7
		busy && $stable(busy) && $stable(flick) |=> run_led == $past(flick) && err_led == $past(flick))
		else $error("indicators not flickering");
	a_busoff_lit: assert property (@(posedge mclk) disable iff (rst) // RULE17
		!busy && can_bus_off |=> err_led)
		else $error("bus off not lit");
	a_oper_lit: assert property (@(posedge mclk) disable iff (rst) // RULE11
		!busy && !ctrl[CTRL_DL] && nmt == NMT_OPER |=> run_led)
		else $error("operational not lit");
	a_err_dark: assert property (@(posedge mclk) disable iff (rst) // RULE12
		pat_err == PAT_OFF && !can_warn && !can_bus_off |=> !err_led)
		else $error("error indicator lit without error");
	a_sticky_set: assert property (@(posedge mclk) disable iff (rst) // RULE14
		guard_evt |=> err_flag[0])
		else $error("guard event lost");
	a_flash_gap: assert property (@(posedge mclk) disable iff (rst) // RULE9
		pat_q[0] == PAT_F1 && pat_run == PAT_F1 && step[0] == 4'h1 |=> !run_led)
		else $error("single flash lit in gap");
endmodule
`default_nettype wire

/* File: pkg/enc_pkg.sv */
// enc_pkg: constants and types for the encoder node config and indicators
// assumes a 100 MHz node clock and an axi4-lite register port
package enc_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_TERM = 8'h04;
	localparam logic [7:0] OFF_SCFG = 8'h08;
	localparam logic [7:0] OFF_ERR  = 8'h0C;
	localparam logic [7:0] OFF_STAT = 8'h10;
	// field positions
	localparam int CTRL_DL   = 2;
	localparam int CTRL_ABR  = 3;
	localparam int CTRL_LSS  = 4;
	localparam int SCFG_RATE = 8;
	localparam int ERR_LIVE  = 8;
	// reset values and terminator on value
	localparam logic [7:0] TERM_RST    = 8'h00;
	localparam logic [7:0] TERM_ON_VAL = 8'h01;
	localparam logic [6:0] SCFG_NODE_RST = 7'h1F;
	localparam logic [3:0] SCFG_RATE_RST = 4'h3;
	localparam logic [6:0] NODE_RST    = 7'h20;
	// switch limits and codes
	localparam logic [3:0] TENS_MAX  = 4'h8;
	localparam logic [3:0] UNITS_MAX = 4'h9;
	localparam logic [3:0] RATE_RSV  = 4'h8;
	localparam logic [3:0] RATE_SOFT = 4'h9;
	localparam logic [6:0] NODE_ADD  = 7'h01;
	// indicator timing and bus response codes
	localparam int CLK_KHZ   = 100_000;
	localparam int T_TICK_MS = 50;
	localparam int T_SLOT_MS = 200;
	localparam int TICK_CYC  = T_TICK_MS * CLK_KHZ;
	localparam logic [1:0] SLOT_TICKS = 2'(T_SLOT_MS / T_TICK_MS - 1);
	localparam logic [3:0] PAUSE_SLOTS = 4'h5;
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	typedef enum logic [1:0] {
		NMT_INIT = 2'h0,
		NMT_PREOP = 2'h1,
		NMT_OPER = 2'h2,
		NMT_STOP = 2'h3
	} enc_nmt_t;

	typedef enum logic [2:0] {
		PAT_OFF, PAT_ON, PAT_FLICK, PAT_BLINK,
		PAT_F1, PAT_F2, PAT_F3, PAT_F4
	} enc_pat_t;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} enc_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} enc_axi_rsp_t;
endpackage

/* File: bench/enc_host_model.sv */
// enc_host_model: axi4-lite master standing in for the network master
// assumes one caller at a time and a shared node clock
`timescale 1ns/1ps
`default_nettype none
module enc_host_model
	import enc_pkg::*;
(
	input  wire logic         mclk,    // node clock
	output enc_axi_req_t      axi_req, // requests out
	input  wire enc_axi_rsp_t axi_rsp  // answers in
);
	// idle bus from time zero
	initial axi_req = '0;

	// one write, each channel let go when taken, lines scrambled after
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge mclk);
		axi_req.awvalid <= 1'b1;
		axi_req.awaddr  <= a;
		axi_req.wvalid  <= 1'b1;
		axi_req.wdata   <= d;
		axi_req.wstrb   <= 4'hF;
		axi_req.bready  <= 1'b1;
		do begin
			@(posedge mclk);
			if (axi_req.awvalid && axi_rsp.awready) begin
				axi_req.awvalid <= 1'b0;
				axi_req.awaddr  <= ~a;
			end
			if (axi_req.wvalid && axi_rsp.wready) begin
				axi_req.wvalid <= 1'b0;
				axi_req.wdata  <= ~d;
			end
		end while (!(axi_rsp.bvalid && axi_req.bready));
		r = axi_rsp.bresp;
		axi_req.bready <= 1'b0;
	endtask

	// one read, data taken at the handshake edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge mclk);
		axi_req.arvalid <= 1'b1;
		axi_req.araddr  <= a;
		axi_req.rready  <= 1'b1;
		do begin
			@(posedge mclk);
			if (axi_req.arvalid && axi_rsp.arready) begin
				axi_req.arvalid <= 1'b0;
				axi_req.araddr  <= ~a;
			end
		end while (!(axi_rsp.rvalid && axi_req.rready));
		d = axi_rsp.rdata;
		r = axi_rsp.rresp;
		axi_req.rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: bench/tb_enc_node_ind.sv */
// tb_enc_node_ind: self-checking bench for switch decode, leds, terminator
// assumes enc_host_model as bus master and a 4-cycle indicator tick
`timescale 1ns/1ps
`default_nettype none
module tb_enc_node_ind;
	import enc_pkg::*;
	localparam int ON_N[8] = '{0, 1920, 960, 960, 320, 480, 576, 640};
	localparam int UP_N[8] = '{0, 0, 240, 60, 20, 30, 36, 40};
	logic         mclk, rst, can_warn, can_bus_off, guard_evt, sync_to_evt, pdo_to_evt;
	logic         soft_cfg, term_on, run_led, err_led;
	logic [3:0]   tens_digit_switch, units_digit_switch, bit_rate_selector_switch;
	logic [6:0]   node_id;
	logic [2:0]   rate_code;
	logic [31:0]  rdat;
	logic [1:0]   resp;
	enc_axi_req_t axi_req;
	enc_axi_rsp_t axi_rsp;
	int           bad_count, samples_checked;

	enc_node_ind #(.TICK_CYC_P(4)) i_dut (.mclk, .rst, .axi_req, .axi_rsp, .tens_digit_switch,
		.units_digit_switch, .bit_rate_selector_switch, .can_warn, .can_bus_off, .guard_evt,
		.sync_to_evt, .pdo_to_evt, .node_id, .rate_code, .soft_cfg, .term_on, .run_led, .err_led);
	enc_host_model host (.mclk, .axi_req, .axi_rsp);

	// 100 MHz clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
		samples_checked++;
		if (seen !== want) begin
			bad_count++;
			$display("unexpected at %0t: %s seen %h want %h", $time, what, seen, want);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic settle;
		repeat (8) @(posedge mclk);
	endtask

	// reset values seen while reset is held
	task automatic t_reset;
		repeat (16) @(posedge mclk);
		check(32'(node_id), 32'(NODE_RST), "reset node");
		check(32'(rate_code), 32'h3, "reset rate");
		check(32'({term_on, run_led, err_led}), 32'h0, "reset outputs");
		rst <= 1'b0;
		settle;
		$display("done reset");
	endtask

	// rate codes 0 to 8, boundary and reserved addresses
	task automatic t_switch;
		for (int k = 0; k < 8; k++) begin
			bit_rate_selector_switch <= 4'(k);
			settle;
			check(32'(rate_code), k, "rate code");
			check(32'(node_id), 32'd32, "node id");
		end
		tens_digit_switch <= 4'h8;
		units_digit_switch <= 4'h9;
		settle;
		check(32'(node_id), 32'd90, "top address");
		tens_digit_switch <= 4'h9;
		units_digit_switch <= 4'h0;
		settle;
		check(32'(node_id), 32'd90, "reserved address held");
		host.rd(OFF_STAT, rdat, resp);
		check(32'(rdat[13]), 32'h1, "config error flag");
		tens_digit_switch <= 4'h3;
		units_digit_switch <= 4'h1;
		bit_rate_selector_switch <= RATE_RSV;
		settle;
		check(32'(rate_code), 32'h7, "reserved rate held");
		bit_rate_selector_switch <= 4'h3;
		settle;
		check(32'(node_id), 32'd32, "node restored");
		$display("done switch");
	endtask

	// rate code 9 hands node and rate to software
	task automatic t_soft;
		bit_rate_selector_switch <= RATE_SOFT;
		settle;
		check(32'(soft_cfg), 32'h1, "soft mode");
		check(32'(node_id), 32'(SCFG_NODE_RST) + 32'h1, "soft node");
		host.wr(OFF_SCFG, 32'h0000_060A, resp);
		tens_digit_switch <= 4'h0;
		settle;
		check(32'(node_id), 32'h0B, "written node");
		check(32'(rate_code), 32'h6, "written rate");
		tens_digit_switch <= 4'h3;
		bit_rate_selector_switch <= 4'h3;
		settle;
		check(32'(soft_cfg), 32'h0, "switch mode");
		$display("done soft");
	endtask

	// unmapped access, terminator on, reset turns it off
	task automatic t_term;
		host.wr(8'h14, 32'h1, resp);
		check(32'(resp), 32'(RESP_ERR), "unmapped write");
		host.rd(8'h14, rdat, resp);
		check(32'(resp), 32'(RESP_ERR), "unmapped read");
		check(rdat, 32'h0, "unmapped data");
		host.wr(OFF_TERM, 32'(TERM_ON_VAL), resp);
		settle;
		check(32'(term_on), 32'h1, "terminator on");
		host.rd(OFF_TERM, rdat, resp);
		check(rdat, 32'h1, "terminator readback");
		rst <= 1'b1;
		settle;
		check(32'(term_on), 32'h0, "terminator off");
		rst <= 1'b0;
		settle;
		$display("done term");
	endtask

	// set state, then count lit cycles and rising edges over 1920 cycles
	task automatic led_step(input logic [4:0] c, input logic [4:0] lv, input enc_pat_t rp, ep);
		int on_r, up_r, on_e, up_e;
		logic pr, pe;
		host.wr(OFF_CTRL, {27'h0, c}, resp);
		can_warn <= lv[0];
		can_bus_off <= lv[1];
		{pdo_to_evt, sync_to_evt, guard_evt} <= lv[4:2];
		@(posedge mclk);
		{pdo_to_evt, sync_to_evt, guard_evt} <= 3'h0;
		repeat (40) @(posedge mclk);
		{on_r, up_r, on_e, up_e} = '0;
		{pr, pe} = {run_led, err_led};
		repeat (1920) begin
			@(negedge mclk);
			on_r += int'(run_led);
			on_e += int'(err_led);
			up_r += int'(run_led & !pr);
			up_e += int'(err_led & !pe);
			{pr, pe} = {run_led, err_led};
		end
		check(on_r, ON_N[rp], "run lit");
		check(up_r, UP_N[rp], "run pulses");
		check(on_e, ON_N[ep], "err lit");
		check(up_e, UP_N[ep], "err pulses");
	endtask

	// indicator patterns for each state and error
	task automatic t_leds;
		led_step(5'h00, 5'h00, PAT_OFF, PAT_OFF);
		led_step(5'h01, 5'h00, PAT_BLINK, PAT_OFF);
		led_step(5'h03, 5'h00, PAT_F1, PAT_OFF);
		led_step(5'h02, 5'h00, PAT_ON, PAT_OFF);
		led_step(5'h06, 5'h00, PAT_F3, PAT_OFF);
		led_step(5'h02, 5'h01, PAT_ON, PAT_F1);
		led_step(5'h02, 5'h05, PAT_ON, PAT_F2);
		led_step(5'h02, 5'h09, PAT_ON, PAT_F3);
		led_step(5'h02, 5'h11, PAT_ON, PAT_F4);
		led_step(5'h02, 5'h03, PAT_ON, PAT_ON);
		led_step(5'h0A, 5'h03, PAT_FLICK, PAT_FLICK);
		led_step(5'h12, 5'h00, PAT_FLICK, PAT_FLICK);
		host.wr(OFF_ERR, 32'h7, resp);
		led_step(5'h02, 5'h00, PAT_ON, PAT_OFF);
		@(posedge mclk);
		tens_digit_switch <= 4'h9;
		led_step(5'h02, 5'h00, PAT_ON, PAT_BLINK);
		$display("done leds");
	endtask

	// main sequence
	initial begin
		rst = 1'b1;
		{can_warn, can_bus_off, guard_evt, sync_to_evt, pdo_to_evt} = '0;
		tens_digit_switch = 4'h3;
		units_digit_switch = 4'h1;
		bit_rate_selector_switch = 4'h3;
		bad_count = 0;
		samples_checked = 0;
		t_reset;
		t_switch;
		t_soft;
		t_term;
		t_leds;
		finish_test;
	end

	// watchdog against a hung handshake
	initial begin
		#1_000_000;
		bad_count++;
		finish_test;
	end
endmodule
`default_nettype wire
